// [frs_checker_assertions.sv]
// Port checker for the field reversal sequencer
`default_nettype none
`include "frs_regs.vh"
module frs_checker #(
  parameter int BRAKE_CYCLES = 4
) (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        direction_select_source,
  input wire logic        brake_reversal_source,
  input wire logic        line_contactor_closed,
  input wire logic        armature_current_zero,
  input wire logic [1:0]  field_contactor_cmd,
  input wire logic        armature_pulse_inhibit,
  input wire logic        field_pulse_inhibit,
  input wire logic        speed_invert,
  input wire logic        force_zero_setpoint,
  input wire logic        hold_o72,
  input wire logic        reversal_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       emf_r;
  logic [2:0] sel_r;
  logic [7:0] brk_r;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Raw pin count runs ahead of the synchroniser, so the bound is safe
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      emf_r <= 1'b0;
      sel_r <= 3'h0;
      brk_r <= 8'h00;
    end else begin
      if (wr && addr == `FRS_OFS_CFG)
        emf_r <= wdata[1:0] == `FRS_SRC_EMF;
      sel_r <= {sel_r[1:0], direction_select_source};
      brk_r <= (brake_reversal_source && line_contactor_closed) ?
               brk_r + {7'h00, brk_r != 8'hFF} : 8'h00;
    end
  end
  ////////////////////////////////////////////////////////////
  AST_CMD_EXCL: assert property (field_contactor_cmd != 2'h3)
    else $error("both contactors commanded");
  AST_CMD_DIR: assert property (
    !reversal_busy && !hold_o72 && field_contactor_cmd != 2'h0
    && sel_r == {3{direction_select_source}}
    |-> field_contactor_cmd == {direction_select_source, !direction_select_source})
    else $error("idle contactor does not follow select");
  AST_ARM_ZERO: assert property (
    $rose(armature_pulse_inhibit) |-> $past(armature_current_zero))
    else $error("armature inhibited with current flowing");
  AST_BOTH_INH: assert property (
    $rose(armature_pulse_inhibit) |-> field_pulse_inhibit || hold_o72)
    else $error("field firing not inhibited with armature");
  AST_OPEN_INH: assert property (
    $fell(field_contactor_cmd != 2'h0) |-> field_pulse_inhibit && armature_pulse_inhibit)
    else $error("contactor opened with firing enabled");
  AST_MAKE_GAP: assert property (
    $past(field_contactor_cmd) != 2'h0 && field_contactor_cmd != 2'h0
    |-> $stable(field_contactor_cmd))
    else $error("contactors swapped without open gap");
  AST_EMF_INV: assert property (emf_r |-> !speed_invert)
    else $error("speed inverted with EMF source");
  AST_FIELD_EN: assert property (
    $fell(field_pulse_inhibit) |-> armature_pulse_inhibit && field_contactor_cmd != 2'h0)
    else $error("field enabled out of order");
  AST_BRAKE_TIME: assert property (
    $rose(force_zero_setpoint) |-> brk_r >= BRAKE_CYCLES)
    else $error("braking started on a short request");
  AST_O72_ENTRY: assert property (
    $rose(hold_o72) |-> force_zero_setpoint && armature_pulse_inhibit)
    else $error("hold state entered out of order");
  AST_O72_HOLD: assert property (
    brake_reversal_source [*3] ##0 hold_o72 ##0 force_zero_setpoint
    |=> force_zero_setpoint && armature_pulse_inhibit)
    else $error("hold state left with request high");
  cover property ($rose(hold_o72));
  cover property ($fell(reversal_busy) && field_contactor_cmd == 2'h2);
  cover property ($rose(speed_invert));
endmodule
`default_nettype wire

// [frs_field_model.sv]
// Field circuit and armature current model facing the sequencer
`default_nettype none
module frs_field_model (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        slow,
  input wire logic        field_pulse_inhibit,
  input wire logic        reversal_busy,
  input wire logic [1:0]  field_contactor_cmd,
  output logic            armature_current_zero,
  output logic            speed_below_min,
  output logic [15:0]     field_current_actual
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  cnt_r;
  logic [15:0] fc_r;
  logic [15:0] step;
  // Slow mode stretches every response so each wait is really exercised
  assign step = slow ? 16'h0010 : 16'h0100;
  assign armature_current_zero = cnt_r >= (slow ? 8'h18 : 8'h03);
  assign speed_below_min = cnt_r >= (slow ? 8'h0C : 8'h02);
  assign field_current_actual = fc_r;
  // Field builds only with firing on and a contactor closed
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 8'h00;
      fc_r <= 16'h0000;
    end else begin
      cnt_r <= reversal_busy ? cnt_r + {7'h00, cnt_r != 8'hFF} : 8'h00;
      if (field_pulse_inhibit || field_contactor_cmd == 2'h0)
        fc_r <= fc_r > step ? fc_r - step : 16'h0000;
      else if (fc_r < 16'h0400)
        fc_r <= fc_r + step;
    end
  end
endmodule
`default_nettype wire

// [frs_field_reversal.v]
// Field reversal sequencer: contactor commands, pulse inhibits, waits and braking
//
// Added by the designer: the register addresses and strobed register access.
`default_nettype none
`include "frs_regs.vh"

// How it works
// R1: Two contactor commands, positive and negative field
// R2: Select low gives positive, high gives negative
// R3: Select level change starts a field reversal
// R4: Running reversal finishes, select changes ignored
// R5: Select reversal only without active brake request
// R6: Wait armature zero, inhibit armature, hold o1.4
// R7: Inhibit field pulses, wait field below minimum
// R8: After wait 0, open the active contactor
// R9: After wait 1, close the new contactor
// R10: Invert speed sign unless source is EMF
// R11: After wait 2, re-enable field pulses
// R12: Field above setpoint times factor, wait 3
// R13: Brake request held 30 ms, contactor closed
// R14: Brake reversal only when speed already negative
// R15: Zero setpoint, speed below min, zero current, o7.2
// R16: Hold o7.2 while brake request stays high
// R17: Mismatched field after braking reverses with wait 4
// R18: After brake stay o7.2 until stop and switch-on
// R19: Setpoint filter zero is the configurer's duty
// R20: Waits count down 0.1 s ticks from settings
module frs_field_reversal #(
  parameter [31:0] TICK_CYCLES  = `FRS_TICK_CYC,
  parameter [31:0] BRAKE_CYCLES = `FRS_BRAKE_CYC
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  input  wire        direction_select_source,
  input  wire        brake_reversal_source,
  input  wire        line_contactor_closed,
  input  wire        armature_current_zero,
  input  wire        speed_below_min,
  input  wire [15:0] speed_actual,
  input  wire [15:0] field_current_actual,
  input  wire [15:0] field_current_setpoint,
  input  wire        stop_switch_on_ack,
  output wire [1:0]  field_contactor_cmd,
  output wire        armature_pulse_inhibit,
  output wire        field_pulse_inhibit,
  output wire        speed_invert,
  output wire        force_zero_setpoint,
  output wire        hold_o14,
  output wire        hold_o72,
  output wire        reversal_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // States

  localparam [12:0] S_INIT   = 13'h0001;
  localparam [12:0] S_IDLE   = 13'h0002;
  localparam [12:0] S_A_IZ   = 13'h0004;
  localparam [12:0] S_F_OFF  = 13'h0008;
  localparam [12:0] S_W0     = 13'h0010;
  localparam [12:0] S_W1     = 13'h0020;
  localparam [12:0] S_W2     = 13'h0040;
  localparam [12:0] S_F_ON   = 13'h0080;
  localparam [12:0] S_W3     = 13'h0100;
  localparam [12:0] S_B_RAMP = 13'h0200;
  localparam [12:0] S_B_IZ   = 13'h0400;
  localparam [12:0] S_B_HOLD = 13'h0800;
  localparam [12:0] S_B_WAIT = 13'h1000;

  localparam [1:0]  PH_DIR   = 2'h0;
  localparam [1:0]  PH_PRE   = 2'h1;
  localparam [1:0]  PH_POST  = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  reg  [1:0]  src_r;
  reg  [7:0]  wait0_r;
  reg  [7:0]  wait1_r;
  reg  [7:0]  wait2_r;
  reg  [7:0]  wait3_r;
  reg  [7:0]  wait4_r;
  reg  [15:0] fld_min_r;
  reg  [15:0] fld_fact_r;

  reg  [12:0] state_r;
  reg  [1:0]  phase_r;
  reg  [1:0]  cmd_r;
  reg         field_dir_r;
  reg         inv_r;
  reg         arm_inh_r;
  reg         fld_inh_r;
  reg         zero_sp_r;
  reg         o72_r;
  reg         ld_r;
  reg  [7:0]  ld_val_r;

  reg         dir_m_r;
  reg         dir_s_r;
  reg         brk_m_r;
  reg         brk_s_r;
  reg  [31:0] brk_cnt_r;
  reg         brk_ok_r;

  wire        tmr_done;
  wire        spd_neg;
  wire        fld_low;
  wire        fld_ok;
  wire [31:0] fld_target;
  wire [31:0] fld_scaled;

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  // Wait settings saturate at 10.0 s
  function [7:0] frs_clamp;
    input [7:0] v;
    begin
      frs_clamp = (v > `FRS_WAIT_MAX) ? `FRS_WAIT_MAX : v;
    end
  endfunction

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      src_r      <= `FRS_RST_SRC;
      wait0_r    <= `FRS_RST_WAIT0;
      wait1_r    <= `FRS_RST_WAIT1;
      wait2_r    <= `FRS_RST_WAIT2;
      wait3_r    <= `FRS_RST_WAIT3;
      wait4_r    <= `FRS_RST_WAIT4;
      fld_min_r  <= `FRS_RST_FLD_MIN;
      fld_fact_r <= `FRS_RST_FLD_FACT;
    end else if (wr) begin
      case (addr)
        `FRS_OFS_CFG: begin
          src_r <= wdata[`FRS_CFG_SRC_LSB +: 2];
        end
        `FRS_OFS_WAIT_A: begin
          wait0_r <= frs_clamp(wdata[`FRS_WAIT0_LSB +: 8]);
          wait1_r <= frs_clamp(wdata[`FRS_WAIT1_LSB +: 8]);
          wait2_r <= frs_clamp(wdata[`FRS_WAIT2_LSB +: 8]);
          wait3_r <= frs_clamp(wdata[`FRS_WAIT3_LSB +: 8]);
        end
        `FRS_OFS_WAIT_B: begin
          wait4_r <= frs_clamp(wdata[`FRS_WAIT4_LSB +: 8]);
        end
        `FRS_OFS_FLD_MIN: begin
          fld_min_r <= wdata[15:0];
        end
        `FRS_OFS_FLD_FACT: begin
          fld_fact_r <= wdata[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Read data valid the cycle after the strobe, zero elsewhere
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 32'h0;
    end else if (rd) begin
      case (addr)
        `FRS_OFS_CFG:      rdata <= {30'h0, src_r};
        `FRS_OFS_WAIT_A:   rdata <= {wait3_r, wait2_r, wait1_r, wait0_r};
        `FRS_OFS_WAIT_B:   rdata <= {24'h0, wait4_r};
        `FRS_OFS_FLD_MIN:  rdata <= {16'h0, fld_min_r};
        `FRS_OFS_FLD_FACT: rdata <= {16'h0, fld_fact_r};
        `FRS_OFS_STATUS:   rdata <= {11'h0, phase_r, o72_r, brk_ok_r, inv_r,
                                     field_dir_r, cmd_r, state_r};
        default:           rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and brake debounce

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dir_m_r <= 1'b0;
      dir_s_r <= 1'b0;
      brk_m_r <= 1'b0;
      brk_s_r <= 1'b0;
    end else begin
      dir_m_r <= direction_select_source;
      dir_s_r <= dir_m_r;
      brk_m_r <= brake_reversal_source;
      brk_s_r <= brk_m_r;
    end
  end

  // Request counts only with the line contactor closed
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      brk_cnt_r <= 32'h0;
      brk_ok_r  <= 1'b0;
    end else if (!brk_s_r || !line_contactor_closed) begin
      brk_cnt_r <= 32'h0;
      brk_ok_r  <= 1'b0;
    end else if (brk_cnt_r >= BRAKE_CYCLES - 32'h1) begin
      brk_ok_r <= 1'b1; // R13
    end else begin
      brk_cnt_r <= brk_cnt_r + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Condition decode

  // Internal speed carries the field inversion
  assign spd_neg    = speed_actual[15] ^ speed_invert; // R14
  assign fld_low    = field_current_actual < fld_min_r; // R7
  assign fld_target = {16'h0, field_current_setpoint} * {16'h0, fld_fact_r};
  assign fld_scaled = {8'h0, field_current_actual, 8'h0};
  assign fld_ok     = fld_scaled > fld_target; // R12

  frs_wait_timer #(
    .W           (8),
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .load    (ld_r),
    .value   (ld_val_r),
    .done    (tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r     <= S_INIT;
      phase_r     <= PH_DIR;
      cmd_r       <= 2'h0;
      field_dir_r <= 1'b0;
      inv_r       <= 1'b0;
      arm_inh_r   <= 1'b0;
      fld_inh_r   <= 1'b0;
      zero_sp_r   <= 1'b0;
      o72_r       <= 1'b0;
      ld_r        <= 1'b0;
      ld_val_r    <= 8'h0;
    end else begin
      ld_r <= 1'b0;
      case (state_r)
        S_INIT: begin
          // Synchroniser still reads its reset low here, so the start is always positive
          field_dir_r <= dir_s_r;
          cmd_r       <= dir_s_r ? 2'h2 : 2'h1; // R2
          state_r     <= S_IDLE;
        end
        S_IDLE: begin
          if (brk_ok_r) begin
            zero_sp_r <= !spd_neg;
            phase_r   <= PH_PRE;
            state_r   <= spd_neg ? S_A_IZ : S_B_RAMP; // R14
          end else if (dir_s_r != field_dir_r) begin // R5
            phase_r <= PH_DIR;
            state_r <= S_A_IZ; // R3
          end
        end
        S_A_IZ: begin
          if (armature_current_zero) begin
            arm_inh_r <= 1'b1; // R6
            fld_inh_r <= 1'b1; // R7
            state_r   <= S_F_OFF;
          end
        end
        S_F_OFF: begin
          if (fld_low) begin
            ld_r     <= 1'b1;
            ld_val_r <= wait0_r; // R20
            state_r  <= S_W0;
          end
        end
        S_W0: begin
          if (tmr_done) begin
            cmd_r    <= 2'h0; // R8
            ld_r     <= 1'b1;
            ld_val_r <= wait1_r;
            state_r  <= S_W1;
          end
        end
        S_W1: begin
          if (tmr_done) begin
            field_dir_r <= !field_dir_r;
            cmd_r       <= field_dir_r ? 2'h1 : 2'h2; // R9
            inv_r       <= !inv_r; // R10
            ld_r        <= 1'b1;
            ld_val_r    <= wait2_r;
            state_r     <= S_W2;
          end
        end
        S_W2: begin
          if (tmr_done) begin
            fld_inh_r <= 1'b0; // R11
            state_r   <= S_F_ON;
          end
        end
        S_F_ON: begin
          if (fld_ok) begin
            ld_r     <= 1'b1;
            ld_val_r <= (phase_r == PH_POST) ? wait4_r : wait3_r; // R17
            state_r  <= S_W3;
          end
        end
        S_W3: begin
          if (tmr_done) begin
            arm_inh_r <= 1'b0; // R12
            if (phase_r == PH_PRE) begin
              zero_sp_r <= 1'b1; // R15
              state_r   <= S_B_RAMP;
            end else if (phase_r == PH_POST) begin
              state_r <= S_B_WAIT; // R18
            end else begin
              state_r <= S_IDLE; // R4
            end
          end
        end
        S_B_RAMP: begin
          if (speed_below_min) begin
            state_r <= S_B_IZ;
          end
        end
        S_B_IZ: begin
          if (armature_current_zero) begin
            arm_inh_r <= 1'b1;
            o72_r     <= 1'b1; // R15
            state_r   <= S_B_HOLD;
          end
        end
        S_B_HOLD: begin
          if (!brk_s_r) begin // R16
            zero_sp_r <= 1'b0;
            arm_inh_r <= 1'b0;
            if (dir_s_r != field_dir_r) begin
              phase_r <= PH_POST; // R17
              state_r <= S_A_IZ;
            end else begin
              state_r <= S_B_WAIT;
            end
          end
        end
        S_B_WAIT: begin
          // Leaves o7.2 only on external stop and switch-on
          if (stop_switch_on_ack) begin
            o72_r   <= 1'b0; // R18
            phase_r <= PH_DIR;
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_INIT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign field_contactor_cmd    = cmd_r; // R1
  assign armature_pulse_inhibit = arm_inh_r;
  assign field_pulse_inhibit    = fld_inh_r;
  // EMF needs no inversion, it follows the field by itself
  assign speed_invert           = inv_r && (src_r != `FRS_SRC_EMF); // R10
  assign force_zero_setpoint    = zero_sp_r;
  assign hold_o14               = arm_inh_r && !o72_r; // R6
  assign hold_o72               = o72_r;
  assign reversal_busy          = !(state_r == S_IDLE) && !(state_r == S_INIT);

endmodule

`default_nettype wire

// [frs_regs.vh]
// Register map, field layout, reset values and timing constants of the field reversal sequencer
`ifndef FRS_REGS_VH
`define FRS_REGS_VH

`define FRS_ADDR_W        8
`define FRS_DATA_W        32

`define FRS_OFS_CFG       8'h00
`define FRS_OFS_WAIT_A    8'h04
`define FRS_OFS_WAIT_B    8'h08
`define FRS_OFS_FLD_MIN   8'h0C
`define FRS_OFS_FLD_FACT  8'h10
`define FRS_OFS_STATUS    8'h14

`define FRS_CFG_SRC_LSB   0
`define FRS_SRC_EMF       2'h3
`define FRS_WAIT0_LSB     0
`define FRS_WAIT1_LSB     8
`define FRS_WAIT2_LSB     16
`define FRS_WAIT3_LSB     24
`define FRS_WAIT4_LSB     0

`define FRS_RST_SRC       2'h0
`define FRS_RST_WAIT0     8'h1E
`define FRS_RST_WAIT1     8'h02
`define FRS_RST_WAIT2     8'h01
`define FRS_RST_WAIT3     8'h1E
`define FRS_RST_WAIT4     8'h1E
`define FRS_WAIT_MAX      8'h64
`define FRS_RST_FLD_MIN   16'h0000
`define FRS_RST_FLD_FACT  16'h0100
`define FRS_FACT_FRAC     8

`define FRS_CLK_MHZ       250
`define FRS_TICK_MS       100
`define FRS_TICK_CYC      (`FRS_TICK_MS * 1000 * `FRS_CLK_MHZ)
`define FRS_BRAKE_MS      30
`define FRS_BRAKE_CYC     (`FRS_BRAKE_MS * 1000 * `FRS_CLK_MHZ)

`endif

// [frs_wait_timer.v]
// Down-counting wait timer in 0.1 s steps for the field reversal sequencer
`default_nettype none

module frs_wait_timer #(
  parameter         W           = 8,
  parameter [31:0]  TICK_CYCLES = 32'd25000000
) (
  input  wire         clk,
  input  wire         reset_n,
  input  wire         load,
  input  wire [W-1:0] value,
  output wire         done
);

  reg [31:0]  pre_r;
  reg [W-1:0] cnt_r;
  reg         busy_r;

  // Prescaler restarts on load so every wait is a full number of ticks
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_r  <= 32'h0;
      cnt_r  <= {W{1'b0}};
      busy_r <= 1'b0;
    end else if (load) begin
      pre_r  <= 32'h0;
      cnt_r  <= value;
      busy_r <= 1'b1;
    end else if (busy_r) begin
      if (cnt_r == {W{1'b0}}) begin
        busy_r <= 1'b0;
      end else if (pre_r == TICK_CYCLES - 32'h1) begin
        pre_r <= 32'h0;
        cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1}; // R20
      end else begin
        pre_r <= pre_r + 32'h1;
      end
    end
  end

  // Load masks done so a stale idle timer never ends a new wait
  assign done = !busy_r && !load;

endmodule

`default_nettype wire

// [tb.sv]
// Self-checking bench for the field reversal sequencer
`default_nettype none
`include "frs_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, reset_n, wr, rd, sel, brk, lcc, ack, slow;
  logic        azero, smin, ainh, finh, inv, fz, o72, busy, o14;
  logic [1:0]  cmd;
  logic [7:0]  addr;
  logic [15:0] spd, fcur;
  logic [31:0] wdata, rdata;
  int          num_errors = 0;
  int          tests_run = 0;
  int          n;

  frs_field_reversal #(.TICK_CYCLES(32'd10), .BRAKE_CYCLES(32'd4)) dut (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .direction_select_source(sel), .brake_reversal_source(brk),
    .line_contactor_closed(lcc), .armature_current_zero(azero), .speed_below_min(smin),
    .speed_actual(spd), .field_current_actual(fcur), .field_current_setpoint(16'h0300),
    .stop_switch_on_ack(ack), .field_contactor_cmd(cmd), .armature_pulse_inhibit(ainh),
    .field_pulse_inhibit(finh), .speed_invert(inv), .force_zero_setpoint(fz),
    .hold_o14(o14), .hold_o72(o72), .reversal_busy(busy));
  frs_field_model u_model (.clk(clk), .reset_n(reset_n), .slow(slow),
    .field_pulse_inhibit(finh), .reversal_busy(busy), .field_contactor_cmd(cmd),
    .armature_current_zero(azero), .speed_below_min(smin), .field_current_actual(fcur));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return busy;
      1: return o72;
      2: return cmd == 2'h1;
      3: return cmd == 2'h0;
      default: return ainh;
    endcase
  endfunction
  // Bounded poll; a timeout shows up as a mismatch
  task automatic wait_for(input int s, input logic v);
    int k;
    k = 0;
    while (sig(s) !== v && k < 3000) begin
      @(negedge clk);
      k++;
    end
    chk(sig(s), v);
  endtask
  task automatic end_sim;
    $display("mismatches=%0d comparisons=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    end_sim;
  end
  ////////////////////////////////////////////////////////////
  initial begin
    {reset_n, wr, rd, sel, brk, ack, slow} = 7'h00;
    lcc = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    spd = 16'h0100;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rd_chk(`FRS_OFS_WAIT_A, 32'h1E01021E);
    rd_chk(`FRS_OFS_WAIT_B, 32'h0000001E);
    rd_chk(`FRS_OFS_FLD_FACT, 32'h00000100);
    rd_chk(`FRS_OFS_STATUS, 32'h00002002);
    wr_reg(8'h40, 32'hFFFFFFFF);
    rd_chk(8'h40, 32'h00000000);
    wr_reg(`FRS_OFS_WAIT_B, 32'h000000FF);
    rd_chk(`FRS_OFS_WAIT_B, 32'h00000064);
    wr_reg(`FRS_OFS_WAIT_A, 32'h02010302);
    wr_reg(`FRS_OFS_WAIT_B, 32'h00000002);
    wr_reg(`FRS_OFS_FLD_MIN, 32'h00000080);
    wr_reg(`FRS_OFS_CFG, 32'h00000003);
    // EMF speed source with a sluggish converter
    slow <= 1'b1;
    sel <= 1'b1;
    wait_for(0, 1'b1);
    wait_for(0, 1'b0);
    chk({cmd, inv}, 3'h4);
    wr_reg(`FRS_OFS_CFG, 32'h00000000);
    // Select bounces while the reversal runs
    slow <= 1'b0;
    sel <= 1'b0;
    wait_for(0, 1'b1);
    @(posedge clk) sel <= 1'b1;
    wait_for(3, 1'b1);
    chk(o14, 1'b1);
    n = 0;
    while (cmd === 2'h0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(n >= 21 && n <= 34, 1'b1);
    @(posedge clk) sel <= 1'b0;
    wait_for(0, 1'b0);
    repeat (10) @(negedge clk);
    chk({busy, cmd}, 3'h1);
    // Short request, then a request without line contactor
    @(posedge clk) brk <= 1'b1;
    repeat (2) @(posedge clk);
    brk <= 1'b0;
    @(posedge clk) lcc <= 1'b0;
    brk <= 1'b1;
    repeat (20) @(negedge clk);
    chk(fz, 1'b0);
    @(posedge clk) lcc <= 1'b1;
    wait_for(1, 1'b1);
    chk({cmd, fz, inv, o14}, 5'h0C);
    repeat (20) @(negedge clk);
    chk(o72, 1'b1);
    @(posedge clk) brk <= 1'b0;
    repeat (10) @(posedge clk);
    ack <= 1'b1;
    @(posedge clk) ack <= 1'b0;
    wait_for(0, 1'b0);
    // Request while already decelerating: field turns first
    @(posedge clk) spd <= 16'hFF00;
    brk <= 1'b1;
    wait_for(1, 1'b1);
    chk({cmd, inv}, 3'h5);
    @(posedge clk) brk <= 1'b0;
    wait_for(2, 1'b1);
    // Ack is only heard once the post-brake reversal has ended
    wait_for(4, 1'b0);
    chk(o72, 1'b1);
    @(posedge clk) ack <= 1'b1;
    @(posedge clk) ack <= 1'b0;
    wait_for(1, 1'b0);
    wait_for(0, 1'b0);
    end_sim;
  end
endmodule
bind frs_field_reversal frs_checker #(.BRAKE_CYCLES(BRAKE_CYCLES)) u_chk (.clk, .reset_n,
  .addr, .wdata, .wr, .direction_select_source, .brake_reversal_source,
  .line_contactor_closed, .armature_current_zero, .field_contactor_cmd,
  .armature_pulse_inhibit, .field_pulse_inhibit, .speed_invert, .force_zero_setpoint,
  .hold_o72, .reversal_busy);
`default_nettype wire
